/* File: include/fsr_cfg.svh */
// Purpose: constants of the flash reset and operation timing link
// Assumes: system clock of 20 MHz, sizes below are fixed by the link format
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH

`define FSR_CLK_MHZ 20
`define FSR_CLK_PERIOD_NS 50

// instruction codes
`define FSR_OP_SOFT_RESET 8'hF0
`define FSR_OP_MODE_CLEAR 8'hFF
`define FSR_OP_WRITE_REGS 8'h01
`define FSR_OP_PAGE_PROG 8'h02
`define FSR_OP_WRITE_DIS 8'h04
`define FSR_OP_READ_STATUS 8'h05
`define FSR_OP_WRITE_EN 8'h06
`define FSR_OP_BULK_ERASE 8'h60
`define FSR_OP_SECTOR_ERASE 8'hD8
`define FSR_OP_ERASE_SUSPEND 8'h75
`define FSR_OP_ERASE_RESUME 8'h7A
`define FSR_OP_PROG_SUSPEND 8'h85
`define FSR_OP_PROG_RESUME 8'h8A
`define FSR_OP_CONT_READ_ENTER 8'hEB

// status register one and config_reg_one field positions
`define FSR_SR1_WIP 0
`define FSR_SR1_WEL 1
`define FSR_SR1_BP_LSB 2
`define FSR_CR1_FREEZE 1
`define FSR_CR1_PARAM_LOC 2
`define FSR_CR1_BP_VOLATILITY 3
`define FSR_CR1_FROM_BOTTOM 5
`define FSR_BP_RESET 3'h0

// frame sizes in link clock edges
`define FSR_BITS_OPCODE 6'd8
`define FSR_BITS_WRITE_REGS 6'd24

// embedded operation times
`define FSR_PAGE_PROG_TIME_US 340
`define FSR_PAGE_PROG_MAX_US 750
`define FSR_SECTOR_ERASE_TIME_MS 520
`define FSR_SECTOR_ERASE_MAX_MS 2600
`define FSR_BULK_ERASE_TIME_S 103
`define FSR_BULK_ERASE_MAX_S 460
`define FSR_PROG_SUSPEND_LATENCY_US 40
`define FSR_ERASE_SUSPEND_LATENCY_US 45
`define FSR_RESUME_TO_SUSPEND_NS 60
`define FSR_RESET_RECOVERY_US 35

`define FSR_PAGE_PROG_CYCLES (`FSR_PAGE_PROG_TIME_US * `FSR_CLK_MHZ)
`define FSR_SECTOR_ERASE_CYCLES (`FSR_SECTOR_ERASE_TIME_MS * 1000 * `FSR_CLK_MHZ)
`define FSR_BULK_ERASE_CYCLES (`FSR_BULK_ERASE_TIME_S * 1000000 * `FSR_CLK_MHZ)
`define FSR_PROG_SUSPEND_CYCLES (`FSR_PROG_SUSPEND_LATENCY_US * `FSR_CLK_MHZ)
`define FSR_ERASE_SUSPEND_CYCLES (`FSR_ERASE_SUSPEND_LATENCY_US * `FSR_CLK_MHZ)
`define FSR_RESET_RECOVERY_CYCLES (`FSR_RESET_RECOVERY_US * `FSR_CLK_MHZ)
`define FSR_RESUME_GAP_CYCLES \
   ((`FSR_RESUME_TO_SUSPEND_NS + `FSR_CLK_PERIOD_NS - 1) / `FSR_CLK_PERIOD_NS)

// host side
`define FSR_SCK_HALF_CYCLES 4
`define FSR_CS_HIGH_CYCLES 6
`define FSR_REG_CTRL 8'h00
`define FSR_REG_TXDATA 8'h04
`define FSR_REG_STATUS 8'h08

`endif

/* File: include/fsr_pkg.sv */
// Purpose: types shared by both ends of the flash reset link
// Assumes: fsr_cfg.svh constants
// Notes: one packed state struct per clock domain of each end, two (frame and capture) in the flash sck domain
package fsr_pkg;

   typedef enum logic [3:0] {
      FSR_IDLE = 4'b0001,
      FSR_BUSY = 4'b0010,
      FSR_SUSP = 4'b0100,
      FSR_RECOV = 4'b1000
   } fsr_dev_state_t;

   typedef enum logic [2:0] {
      FSR_KIND_PROG = 3'b001,
      FSR_KIND_SECTOR = 3'b010,
      FSR_KIND_BULK = 3'b100
   } fsr_op_kind_t;

   typedef enum logic [2:0] {
      FSR_H_IDLE = 3'b001,
      FSR_H_SHIFT = 3'b010,
      FSR_H_GAP = 3'b100
   } fsr_host_state_t;

   typedef struct packed {
      logic cs1;
      logic cs2;
      logic csPrev;
      logic strap1;
      logic strap2;
      logic strapDone;
      logic [1:0] strapAge;
      logic wel;
      logic freeze;
      logic lock;
      logic fromBottom;
      logic paramLoc;
      logic bpVolatile;
      logic [2:0] bpLevel;
      logic contRead;
      fsr_dev_state_t state;
      fsr_op_kind_t opKind;
      logic suspPending;
      logic [31:0] remain;
      logic [15:0] latency;
   } fsr_dev_core_t;

   typedef struct packed {
      logic [5:0] bitCnt;
      logic [7:0] soShift;
      logic soOe;
      logic [7:0] stat1;
      logic [7:0] stat2;
   } fsr_dev_frame_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [15:0] payload;
      logic [5:0] bits;
   } fsr_dev_capture_t;

   typedef struct packed {
      fsr_host_state_t state;
      logic [10:0] ctrl;
      logic [15:0] txData;
      logic [7:0] divCnt;
      logic [5:0] bitsLeft;
      logic [23:0] txShift;
      logic [7:0] rxShift;
      logic [7:0] rxByte;
      logic [3:0] gapCnt;
      logic sck;
      logic csN;
      logic io0;
      logic [3:0] ioOeN;
      logic io1s1;
      logic io1s2;
      logic mbrPending;
      logic cmdPending;
      logic curMbr;
      logic curResume;
      logic busy;
      logic [31:0] rdata;
   } fsr_host_t;

endpackage : fsr_pkg

/* File: include/fsr_link_if.sv */
// Purpose: serial flash link between host controller and flash device
// Assumes: output enables are active low, an idle line reads as one
// Notes: io is the resolved wire level seen by both ends
interface fsr_link_if;
   logic sck;
   logic csN;
   logic [3:0] hostIoOut;
   logic [3:0] hostIoOeN;
   logic [3:0] devIoOut;
   logic [3:0] devIoOeN;
   logic [3:0] io;

   // weak pull-up where nobody drives
   assign io = (~hostIoOeN & hostIoOut) | (~devIoOeN & devIoOut) | (hostIoOeN & devIoOeN);

   modport host (output sck, output csN, output hostIoOut, output hostIoOeN, input io);
   modport flash (input sck, input csN, input io, output devIoOut, output devIoOeN);
endinterface : fsr_link_if

/* File: hdl/fsr_flash_end.sv */
// Purpose: flash device end: software reset, mode bit clear and embedded op timing
// Assumes: host keeps sck still while csN is high and for a few clk cycles after
// Notes: link logic runs on sck, execution runs on clk after csN rises
//
// Decided for this implementation: strobed register access and the register offsets.
`include "fsr_cfg.svh"

module fsr_flash_end #(
   parameter int unsigned PAGE_PROG_CYCLES = `FSR_PAGE_PROG_CYCLES,
   parameter int unsigned SECTOR_ERASE_CYCLES = `FSR_SECTOR_ERASE_CYCLES,
   parameter int unsigned BULK_ERASE_CYCLES = `FSR_BULK_ERASE_CYCLES,
   parameter int unsigned PROG_SUSPEND_CYCLES = `FSR_PROG_SUSPEND_CYCLES,
   parameter int unsigned ERASE_SUSPEND_CYCLES = `FSR_ERASE_SUSPEND_CYCLES,
   parameter int unsigned RESET_RECOVERY_CYCLES = `FSR_RESET_RECOVERY_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic clockEnable,
   input wire logic reset,
   // power-on value of the protection lock
   input wire logic lockStrap,
   // link
   fsr_link_if.flash link,
   // device state
   output logic writeInProgress,
   output logic opSuspended,
   output logic contReadMode,
   output logic [2:0] blockProtLevel,
   output logic freezeBit,
   output logic sectorProtLockBit,
   output logic protectFromBottomSel,
   output logic paramSectorLocation,
   output logic blockProtVolatility,
   output logic writeEnableLatch
);

   fsr_pkg::fsr_dev_core_t s;
   fsr_pkg::fsr_dev_core_t next_s;
   fsr_pkg::fsr_dev_frame_t f;
   fsr_pkg::fsr_dev_frame_t next_f;
   fsr_pkg::fsr_dev_capture_t c;
   fsr_pkg::fsr_dev_capture_t next_c;
   logic frameClear;
   logic wipNow;
   logic [7:0] statusWord;

   // a suspend or resume only counts for the kind of operation in flight
   function automatic logic kindMatch(input logic [7:0] op, input fsr_pkg::fsr_op_kind_t kind,
                                      input logic [7:0] progOp, input logic [7:0] eraseOp);
      kindMatch = (kind == fsr_pkg::FSR_KIND_PROG) ? (op == progOp) : (op == eraseOp);
   endfunction : kindMatch

   function automatic logic [15:0] latencyLoad(input int unsigned cycles);
      latencyLoad = 16'(cycles - 1);
   endfunction : latencyLoad

   assign wipNow = (s.state == fsr_pkg::FSR_BUSY) || (s.state == fsr_pkg::FSR_RECOV);
   assign statusWord = {3'h0, s.bpLevel, s.wel, wipNow};

   // ---------------- link domain ----------------
   // csN high clears the frame position; only a frame start can follow
   assign frameClear = reset | link.csN;

   always_comb begin
      next_f = f;
      next_f.stat1 = statusWord;
      next_f.stat2 = f.stat1;
      if (f.bitCnt != 6'h3F) begin
         next_f.bitCnt = f.bitCnt + 6'h01;
      end
      if (f.bitCnt == 6'h07) begin
         next_f.soShift = f.stat2;
         next_f.soOe = ({c.opcode[6:0], link.io[0]} == `FSR_OP_READ_STATUS);
      end else begin
         next_f.soShift = {f.soShift[6:0], f.soShift[7]};
      end
   end

   always_ff @(posedge link.sck or posedge frameClear) begin
      if (frameClear) begin
         f <= '0;
      end else begin
         f <= next_f;
      end
   end

   // only io0 is sampled; io1 to io3 are ignored while an instruction shifts in
   always_comb begin
      next_c = c;
      next_c.bits = next_f.bitCnt;
      if (f.bitCnt < `FSR_BITS_OPCODE) begin
         next_c.opcode = {c.opcode[6:0], link.io[0]};
      end else if (f.bitCnt < `FSR_BITS_WRITE_REGS) begin
         next_c.payload = {c.payload[14:0], link.io[0]};
      end
   end

   always_ff @(posedge link.sck or posedge reset) begin
      if (reset) begin
         c <= '0;
      end else begin
         c <= next_c;
      end
   end

   assign link.devIoOut = {2'h0, f.soShift[7], 1'h0};
   assign link.devIoOeN = {2'h3, ~f.soOe, 1'h1};

   // ---------------- clk domain ----------------
   always_comb begin
      logic frameEnd;
      logic opcodeWhole;
      logic [7:0] op;
      frameEnd = 1'b0;
      opcodeWhole = 1'b0;
      op = 8'h00;
      next_s = s;
      next_s.cs1 = link.csN;
      next_s.cs2 = s.cs1;
      next_s.csPrev = s.cs2;
      next_s.strap1 = lockStrap;
      next_s.strap2 = s.strap1;
      // the strap needs two edges to pass both flops before it is taken
      if (!s.strapDone) begin
         if (s.strapAge == 2'h2) begin
            next_s.lock = s.strap2;
            next_s.strapDone = 1'b1;
         end else begin
            next_s.strapAge = s.strapAge + 2'h1;
         end
      end
      unique case (s.state)
         fsr_pkg::FSR_IDLE, fsr_pkg::FSR_SUSP: begin
         end
         fsr_pkg::FSR_BUSY: begin
            if (s.suspPending) begin
               if (s.latency == 16'h0000) begin
                  next_s.state = fsr_pkg::FSR_SUSP;
                  next_s.suspPending = 1'b0;
               end else begin
                  next_s.latency = s.latency - 16'h0001;
               end
            end else if (s.remain == 32'h0000_0000) begin
               next_s.state = fsr_pkg::FSR_IDLE;
               next_s.wel = 1'b0;
            end else begin
               next_s.remain = s.remain - 32'h0000_0001;
            end
         end
         fsr_pkg::FSR_RECOV: begin
            if (s.latency == 16'h0000) begin
               next_s.state = fsr_pkg::FSR_IDLE;
            end else begin
               next_s.latency = s.latency - 16'h0001;
            end
         end
      endcase
      // the captured frame is stable here since sck stands still
      frameEnd = s.cs2 && !s.csPrev;
      opcodeWhole = (c.bits >= `FSR_BITS_OPCODE);
      op = c.opcode;
      if (frameEnd && opcodeWhole) begin
         if (op == `FSR_OP_MODE_CLEAR) begin
            next_s.contRead = 1'b0;
         end else if (s.contRead) begin
            // continuous read swallows every other instruction
         end else if (op == `FSR_OP_SOFT_RESET) begin
            next_s.state = fsr_pkg::FSR_RECOV;
            next_s.latency = latencyLoad(RESET_RECOVERY_CYCLES);
            next_s.suspPending = 1'b0;
            next_s.remain = 32'h0000_0000;
            next_s.wel = 1'b0;
            next_s.opKind = fsr_pkg::FSR_KIND_PROG;
            // freeze, lock and the nonvolatile selects are left alone
            if (s.bpVolatile && !s.freeze) begin
               next_s.bpLevel = `FSR_BP_RESET;
            end
         end else begin
            unique case (s.state)
               fsr_pkg::FSR_IDLE: begin
                  if (op == `FSR_OP_WRITE_EN) begin
                     next_s.wel = 1'b1;
                  end else if (op == `FSR_OP_WRITE_DIS) begin
                     next_s.wel = 1'b0;
                  end else if (op == `FSR_OP_CONT_READ_ENTER) begin
                     next_s.contRead = 1'b1;
                  end else if (op == `FSR_OP_WRITE_REGS && s.wel
                               && c.bits >= `FSR_BITS_WRITE_REGS) begin
                     next_s.wel = 1'b0;
                     if (!s.freeze) begin
                        next_s.bpLevel = c.payload[8 + `FSR_SR1_BP_LSB +: 3];
                        next_s.fromBottom = c.payload[`FSR_CR1_FROM_BOTTOM];
                        next_s.paramLoc = c.payload[`FSR_CR1_PARAM_LOC];
                        next_s.bpVolatile = c.payload[`FSR_CR1_BP_VOLATILITY];
                     end
                     next_s.freeze = s.freeze | c.payload[`FSR_CR1_FREEZE];
                  end else if (s.wel && op == `FSR_OP_PAGE_PROG) begin
                     next_s.state = fsr_pkg::FSR_BUSY;
                     next_s.opKind = fsr_pkg::FSR_KIND_PROG;
                     next_s.remain = 32'(PAGE_PROG_CYCLES - 1);
                  end else if (s.wel && op == `FSR_OP_SECTOR_ERASE) begin
                     next_s.state = fsr_pkg::FSR_BUSY;
                     next_s.opKind = fsr_pkg::FSR_KIND_SECTOR;
                     next_s.remain = 32'(SECTOR_ERASE_CYCLES - 1);
                  end else if (s.wel && op == `FSR_OP_BULK_ERASE) begin
                     next_s.state = fsr_pkg::FSR_BUSY;
                     next_s.opKind = fsr_pkg::FSR_KIND_BULK;
                     next_s.remain = 32'(BULK_ERASE_CYCLES - 1);
                  end
               end
               fsr_pkg::FSR_BUSY: begin
                  if (!s.suspPending && s.opKind != fsr_pkg::FSR_KIND_BULK
                      && kindMatch(op, s.opKind, `FSR_OP_PROG_SUSPEND,
                                   `FSR_OP_ERASE_SUSPEND)) begin
                     next_s.suspPending = 1'b1;
                     next_s.latency = (s.opKind == fsr_pkg::FSR_KIND_PROG)
                        ? latencyLoad(PROG_SUSPEND_CYCLES)
                        : latencyLoad(ERASE_SUSPEND_CYCLES);
                  end
               end
               fsr_pkg::FSR_SUSP: begin
                  if (kindMatch(op, s.opKind, `FSR_OP_PROG_RESUME, `FSR_OP_ERASE_RESUME)) begin
                     next_s.state = fsr_pkg::FSR_BUSY;
                  end
               end
               fsr_pkg::FSR_RECOV: begin
                  // not ready: instructions are dropped until recovery ends
               end
            endcase
         end
      end
   end

   // power-on and hardware reset are the same input: freeze clears, lock reloads
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s <= '{state: fsr_pkg::FSR_IDLE, opKind: fsr_pkg::FSR_KIND_PROG,
                bpLevel: `FSR_BP_RESET, cs1: 1'b1, cs2: 1'b1, csPrev: 1'b1,
                default: '0};
      end else if (clockEnable) begin
         s <= next_s;
      end
   end

   assign writeInProgress = s.state[1] | s.state[3];
   assign opSuspended = s.state[2];
   assign contReadMode = s.contRead;
   assign blockProtLevel = s.bpLevel;
   assign freezeBit = s.freeze;
   assign sectorProtLockBit = s.lock;
   assign protectFromBottomSel = s.fromBottom;
   assign paramSectorLocation = s.paramLoc;
   assign blockProtVolatility = s.bpVolatile;
   assign writeEnableLatch = s.wel;

endmodule : fsr_flash_end

/* File: hdl/fsr_host_end.sv */
// Purpose: host controller end: sends instruction frames ordered by software
// Assumes: sck is made here from clk; io1 is synchronised before use
// Notes: a mode clear frame goes out after reset and ahead of every soft reset
`include "fsr_cfg.svh"

module fsr_host_end #(
   parameter int unsigned SCK_HALF_CYCLES = `FSR_SCK_HALF_CYCLES,
   parameter int unsigned CS_HIGH_CYCLES = `FSR_CS_HIGH_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic clockEnable,
   input wire logic reset,
   // register port
   input wire logic [7:0] address,
   input wire logic [31:0] writeData,
   input wire logic writeStrobe,
   input wire logic readStrobe,
   output logic [31:0] readData,
   output logic busy,
   // link
   fsr_link_if.host link
);

   fsr_pkg::fsr_host_t s;
   fsr_pkg::fsr_host_t next_s;

   function automatic logic [3:0] gapLoad(input logic afterResume);
      int unsigned g;
      g = CS_HIGH_CYCLES;
      if (afterResume && `FSR_RESUME_GAP_CYCLES > g) begin
         g = `FSR_RESUME_GAP_CYCLES;
      end
      gapLoad = 4'(g - 1);
   endfunction : gapLoad

   always_comb begin
      next_s = s;
      next_s.io1s1 = link.io[1];
      next_s.io1s2 = s.io1s1;
      unique case (s.state)
         fsr_pkg::FSR_H_IDLE: begin
            if (s.mbrPending || s.cmdPending) begin
               next_s.state = fsr_pkg::FSR_H_SHIFT;
               next_s.curMbr = s.mbrPending;
               next_s.txShift = s.mbrPending ? 24'hFF_FFFF : {s.ctrl[7:0], s.txData};
               next_s.bitsLeft = s.mbrPending ? 6'd8
                  : 6'd8 + {s.ctrl[9:8], 3'h0} + {2'h0, s.ctrl[10], 3'h0};
               next_s.curResume = !s.mbrPending && (s.ctrl[7:0] == `FSR_OP_PROG_RESUME
                                  || s.ctrl[7:0] == `FSR_OP_ERASE_RESUME);
               next_s.csN = 1'b0;
               next_s.sck = 1'b0;
               next_s.io0 = next_s.txShift[23];
               next_s.ioOeN = 4'hE;
               next_s.divCnt = 8'(SCK_HALF_CYCLES - 1);
            end
         end
         fsr_pkg::FSR_H_SHIFT: begin
            if (s.divCnt != 8'h00) begin
               next_s.divCnt = s.divCnt - 8'h01;
            end else begin
               next_s.divCnt = 8'(SCK_HALF_CYCLES - 1);
               if (!s.sck) begin
                  // synchronised io1 still shows the bit put out before this edge
                  next_s.sck = 1'b1;
                  next_s.rxShift = {s.rxShift[6:0], s.io1s2};
               end else begin
                  next_s.sck = 1'b0;
                  next_s.txShift = {s.txShift[22:0], 1'b0};
                  next_s.io0 = s.txShift[22];
                  next_s.bitsLeft = s.bitsLeft - 6'h01;
                  if (s.bitsLeft == 6'h01) begin
                     next_s.state = fsr_pkg::FSR_H_GAP;
                     next_s.csN = 1'b1;
                     next_s.ioOeN = 4'hF;
                     next_s.rxByte = s.rxShift;
                     next_s.gapCnt = gapLoad(s.curResume);
                     if (s.curMbr) begin
                        next_s.mbrPending = 1'b0;
                     end else begin
                        next_s.cmdPending = 1'b0;
                     end
                  end
               end
            end
         end
         fsr_pkg::FSR_H_GAP: begin
            if (s.gapCnt == 4'h0) begin
               next_s.state = fsr_pkg::FSR_H_IDLE;
            end else begin
               next_s.gapCnt = s.gapCnt - 4'h1;
            end
         end
      endcase
      // orders are refused while a frame is pending or running
      if (writeStrobe && !s.busy) begin
         if (address == `FSR_REG_CTRL) begin
            next_s.ctrl = writeData[10:0];
            next_s.cmdPending = 1'b1;
            if (writeData[7:0] == `FSR_OP_SOFT_RESET) begin
               next_s.mbrPending = 1'b1;
            end
         end else if (address == `FSR_REG_TXDATA) begin
            next_s.txData = writeData[15:0];
         end
      end
      if (readStrobe) begin
         unique case (address)
            `FSR_REG_CTRL: next_s.rdata = {21'h0, s.ctrl};
            `FSR_REG_TXDATA: next_s.rdata = {16'h0, s.txData};
            `FSR_REG_STATUS: next_s.rdata = {16'h0, s.rxByte, 6'h0, s.mbrPending, s.busy};
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end
      next_s.busy = next_s.mbrPending || next_s.cmdPending
                    || (next_s.state != fsr_pkg::FSR_H_IDLE);
   end

   // the mode clear pending at reset is sent first after release
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s <= '{state: fsr_pkg::FSR_H_IDLE, csN: 1'b1, ioOeN: 4'hF, io0: 1'b1,
                mbrPending: 1'b1, busy: 1'b1, io1s1: 1'b1, io1s2: 1'b1, default: '0};
      end else if (clockEnable) begin
         s <= next_s;
      end
   end

   assign readData = s.rdata;
   assign busy = s.busy;
   assign link.sck = s.sck;
   assign link.csN = s.csN;
   assign link.hostIoOut = {3'h0, s.io0};
   assign link.hostIoOeN = s.ioOeN;

endmodule : fsr_host_end

/* File: tb/fsr_link_assertions.sv */
// Purpose: wire checks between the host and flash ends
// Assumes: sck and csN are host flops on clk
// Notes: sck edges are seen through one clk sample
module fsr_link_assertions (
   // clock and reset
   input logic clk,
   input logic reset,
   // link wires
   input logic sck,
   input logic csN,
   input logic [3:0] hostIoOeN,
   input logic [3:0] devIoOeN,
   input logic [3:0] io
);
   logic sckQ;
   logic firstDone;
   logic [5:0] frameRises;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sckQ <= 1'h0;
         firstDone <= 1'h0;
         frameRises <= 6'h00;
      end else begin
         sckQ <= sck;
         firstDone <= firstDone | (csN & (frameRises != 6'h00));
         frameRises <= csN ? 6'h00 : frameRises + {5'h00, sck & !sckQ};
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   a_mbr_soon: assert property ($fell(reset) |-> ##[1:20] !csN) else $error("no frame");
   a_sck_still: assert property (csN |-> !sck) else $error("sck off frame");
   a_io0_driven: assert property (!csN |-> !hostIoOeN[0]) else $error("io0 undriven");
   a_spare_free: assert property (&{hostIoOeN[3:1], devIoOeN[3:2], devIoOeN[0]})
      else $error("spare io driven");
   a_dev_quiet: assert property (csN ##1 csN |-> devIoOeN == 4'hF) else $error("dev drives");
   a_cs_gap: assert property ($rose(csN) |=> csN[*5]) else $error("cs gap short");
   a_sck_half: assert property ($rose(sck) |-> sck[*4] ##1 !sck) else $error("sck half");
   a_mbr_ones: assert property (!firstDone && sck && !sckQ |-> io[0]) else $error("mbr");
   a_frame_bytes: assert property ($rose(csN) |-> frameRises[2:0] == 3'h0 && frameRises != 6'h00)
      else $error("partial byte");
endmodule : fsr_link_assertions

/* File: tb/test_flash_reset_cmd_and_op_timing.sv */
// Purpose: bench joining host and flash ends over the link
// Assumes: op times shortened by parameters so rows settle fast
// Notes: row = ctrl, txdata, settle cycles, status byte, expected state
`include "fsr_cfg.svh"
module test_flash_reset_cmd_and_op_timing;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0, reset = 1'h1, lockStrap = 1'h1, writeStrobe = 1'h0, readStrobe = 1'h0;
   logic ce = 1'h1;
   logic [7:0] address = 8'h00;
   logic [31:0] writeData = 32'h0, readData, rdat;
   logic busy, write_in_progress, susp, cont, frz, lock, bot, par, vol, wel;
   logic [2:0] bp;
   logic [11:0] st;
   int failures = 0, cmp_count = 0;
   logic [59:0] rows [20];
   assign st = {lock, write_in_progress, susp, cont, frz, wel, vol, bot, par, bp};
   fsr_link_if link ();
   fsr_host_end fsr_host_end_inst (.clk(clk), .clockEnable(ce), .reset(reset),
      .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
      .readStrobe(readStrobe), .readData(readData), .busy(busy), .link(link));
   fsr_flash_end #(.PAGE_PROG_CYCLES(1000), .SECTOR_ERASE_CYCLES(2000), .BULK_ERASE_CYCLES(60),
      .PROG_SUSPEND_CYCLES(5), .ERASE_SUSPEND_CYCLES(5))
      fsr_flash_end_inst (.clk(clk), .clockEnable(ce), .reset(reset), .lockStrap(lockStrap),
      .link(link), .writeInProgress(write_in_progress), .opSuspended(susp), .contReadMode(cont),
      .blockProtLevel(bp), .freezeBit(frz), .sectorProtLockBit(lock), .writeEnableLatch(wel),
      .protectFromBottomSel(bot), .paramSectorLocation(par), .blockProtVolatility(vol));
   fsr_link_assertions fsr_link_assertions_inst (.clk(clk), .reset(reset), .sck(link.sck),
      .csN(link.csN), .hostIoOeN(link.hostIoOeN), .devIoOeN(link.devIoOeN), .io(link.io));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic give_verdict();
      $display("compares %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict
   // one strobe cycle; read data stands from the cycle after it until the next read
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      address <= a;
      writeData <= d;
      writeStrobe <= w;
      readStrobe <= !w;
      @(posedge clk);
      writeStrobe <= 1'h0;
      readStrobe <= 1'h0;
      #1 rdat = readData;
   endtask : bus
   task automatic idle();
      int i;
      #1;
      for (i = 0; i < 3000 && busy !== 1'h0; i++) begin
         @(posedge clk);
         #1;
      end
      if (busy !== 1'h0) begin
         failures++;
         give_verdict();
      end
   endtask : idle
   initial begin
      forever #25 clk = ~clk;
   end
   initial begin
      int k;
      rows = '{60'h006_0000_014_00_840, 60'h060_0000_014_00_C40, 60'h405_0000_064_00_800,
         60'h006_0000_014_00_840, 60'h0D8_0000_014_00_C40, 60'h075_0000_014_00_A40,
         60'h07A_0000_014_00_C40, 60'h405_0000_9C4_03_800, 60'h006_0000_014_00_840,
         60'h002_0000_014_00_C40, 60'h085_0000_014_00_A40, 60'h08A_0000_014_00_C40,
         60'h005_0000_5DC_00_800, 60'h006_0000_014_00_840, 60'h201_142C_014_00_83D,
         60'h0EB_0000_014_00_93D, 60'h0F0_0000_300_00_838, 60'h006_0000_014_00_878,
         60'h201_0C2E_014_00_8BB, 60'h0F0_0000_300_00_8BB};
      repeat (6) @(posedge clk);
      reset <= 1'h0;
      idle();
      for (k = 0; k < 20; k++) begin
         bus(1'h1, `FSR_REG_TXDATA, {16'h0, rows[k][47:32]});
         bus(1'h1, `FSR_REG_CTRL, {20'h0, rows[k][59:48]});
         idle();
         repeat (rows[k][31:20]) @(posedge clk);
         #1;
         chk("state", {20'h0, rows[k][11:0]}, {20'h0, st});
         if (rows[k][58]) begin
            bus(1'h0, `FSR_REG_STATUS, 32'h0);
            chk("status byte", {24'h0, rows[k][19:12]}, {24'h0, rdat[15:8]});
         end
      end
      bus(1'h0, 8'h0C, 32'h0);
      chk("unmapped read", 32'h0, rdat);
      // a frozen host must not take the order
      ce <= 1'h0;
      bus(1'h1, `FSR_REG_CTRL, 32'h0000_0006);
      repeat (4) @(posedge clk);
      #1;
      chk("frozen busy", 32'h0, {31'h0, busy});
      ce <= 1'h1;
      @(posedge clk);
      lockStrap <= 1'h0;
      reset <= 1'h1;
      @(posedge clk);
      reset <= 1'h0;
      repeat (8) @(posedge clk);
      #1;
      chk("hard reset", 32'h0, {29'h0, frz, lock, write_in_progress});
      idle();
      give_verdict();
   end
endmodule : test_flash_reset_cmd_and_op_timing
